// >>> verilog/clk_gate_pkg.sv
/*
  Constants for the clock output stop / power-down gating block:
  register offsets, field positions, reset values and timing figures.
  Assumes a 125 MHz system clock and a 32-bit APB register bus.
*/
package clk_gate_pkg;

    localparam int unsigned SYS_PERIOD_NS = 8;

    // latency limits, in nanoseconds
    localparam int unsigned PWRUP_MAX_NS = 1000000;
    localparam int unsigned PD_WAKE_MAX_NS = 300000;
    localparam int unsigned STOP_WAKE_MAX_NS = 10;

    // longest times round down, never below one cycle
    localparam int unsigned PWRUP_CYCLES = (PWRUP_MAX_NS / SYS_PERIOD_NS) > 0 ? PWRUP_MAX_NS / SYS_PERIOD_NS : 1;
    localparam int unsigned PD_WAKE_CYCLES = (PD_WAKE_MAX_NS / SYS_PERIOD_NS) > 0 ? PD_WAKE_MAX_NS / SYS_PERIOD_NS : 1;
    localparam int unsigned STOP_WAKE_CYCLES = (STOP_WAKE_MAX_NS / SYS_PERIOD_NS) > 0 ?
        STOP_WAKE_MAX_NS / SYS_PERIOD_NS : 1;

    // system clock cycles per half period of the output clock
    localparam int unsigned HALF_PERIOD_CYCLES = 2;

    // register byte offsets
    localparam logic [11:0] OFS_MODE = 12'h000;
    localparam logic [11:0] OFS_STOPPABLE = 12'h004;
    localparam logic [11:0] OFS_OUT_ENABLE = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;

    // mode register fields
    localparam int unsigned MODE_SLEEP_TRI_BIT = 0;
    localparam int unsigned MODE_STOP_TRI_BIT = 1;
    localparam logic [1:0] MODE_RESET = 2'h0;

    localparam logic [7:0] STOPPABLE_RESET = 8'h00;
    localparam logic [7:0] OUT_ENABLE_RESET = 8'hff;

    // status register fields
    localparam int unsigned STAT_PD_ACTIVE_BIT = 0;
    localparam int unsigned STAT_HALTED_BIT = 1;
    localparam int unsigned STAT_LOCKED_BIT = 2;
    localparam int unsigned STAT_PD_LEVEL_BIT = 3;
    localparam int unsigned STAT_HALT_LEVEL_BIT = 4;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_PARK_PEND,
        ST_DOWN,
        ST_RELOCK
    } pd_state_t;

endpackage

// >>> verilog/pair_gate.sv
/*
  One differential output pair: picks the level and drive enable of the
  true and complement pins from the shared clock phase and park requests.
  Assumes all control inputs are synchronous to MCLK_I.
*/
module pair_gate (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic phase_i,
    input wire logic enable_i,
    input wire logic pd_park_i,
    input wire logic pd_wake_i,
    input wire logic sleep_tri_i,
    input wire logic halted_i,
    input wire logic halt_wake_i,
    input wire logic stop_tri_i,
    output logic true_o,
    output logic true_oe_o,
    output logic comp_o,
    output logic comp_oe_o
);

    logic true_nxt;
    logic true_oe_nxt;
    logic comp_nxt;
    logic comp_oe_nxt;

    always_comb
    begin
        true_nxt = 1'b1;
        true_oe_nxt = 1'b0;
        comp_nxt = 1'b0;
        comp_oe_nxt = 1'b0;
        if (!enable_i)
        begin
            true_nxt = 1'b0;
        end
        else if (pd_park_i)
        begin
            true_oe_nxt = !sleep_tri_i;
        end
        else if (pd_wake_i)
        begin
            true_oe_nxt = 1'b1;
        end
        else if (halted_i)
        begin
            // tri-stated true pin is pulled high again at once on release; the complement stays undriven
            true_oe_nxt = !stop_tri_i || halt_wake_i;
            true_nxt = !stop_tri_i || halt_wake_i;
        end
        else
        begin
            true_nxt = phase_i;
            true_oe_nxt = 1'b1;
            comp_nxt = !phase_i;
            comp_oe_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            true_o <= 1'b0;
            true_oe_o <= 1'b0;
            comp_o <= 1'b0;
            comp_oe_o <= 1'b0;
        end
        else
        begin
            true_o <= true_nxt;
            true_oe_o <= true_oe_nxt;
            comp_o <= comp_nxt;
            comp_oe_o <= comp_oe_nxt;
        end
    end

endmodule

// >>> verilog/clock_output_stop_powerdown.sv
/*
  Output gating of an eight-pair differential clock fanout: power-down
  and clock-halt handling, parking and glitch-free restart, APB registers.
  Assumes MCLK_I stands for the reference clock and runs continuously;
  APB3 master without wait-state expectations.
*/
// The placing of the registers and the APB slave port were left to the implementer.
module clock_output_stop_powerdown #(
    parameter int unsigned NUM_PAIRS = 8,
    parameter int unsigned HALF_PERIOD = clk_gate_pkg::HALF_PERIOD_CYCLES,
    parameter int unsigned RELOCK_CYCLES = clk_gate_pkg::PWRUP_CYCLES
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic POWER_DOWN_N_I,
    input wire logic CLOCK_HALT_N_I,
    output logic [NUM_PAIRS-1:0] CLK_OUT_TRUE_O,
    output logic [NUM_PAIRS-1:0] CLK_OUT_TRUE_OE_O,
    output logic [NUM_PAIRS-1:0] CLK_OUT_COMP_O,
    output logic [NUM_PAIRS-1:0] CLK_OUT_COMP_OE_O,
    output logic PLL_EN_O
);

    localparam int unsigned DIV_W = HALF_PERIOD > 1 ? $clog2(HALF_PERIOD) : 1;
    localparam int unsigned LOCK_W = $clog2(RELOCK_CYCLES + 1);

    if (NUM_PAIRS < 1 || NUM_PAIRS > 8 || HALF_PERIOD < 1 || RELOCK_CYCLES < 1)
    begin : g_bad_params
        $error("clock_output_stop_powerdown: unsupported parameter values");
    end

    // output clock divider
    logic [DIV_W-1:0] div_cnt_r;
    logic phase_r;
    logic half_en;
    logic comp_rise;
    logic true_rise;

    assign half_en = (div_cnt_r == DIV_W'(HALF_PERIOD - 1));
    // complement rises when true falls
    assign comp_rise = half_en && phase_r;
    assign true_rise = half_en && !phase_r;

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            div_cnt_r <= '0;
            phase_r <= 1'b0;
        end
        else if (half_en)
        begin
            div_cnt_r <= '0;
            phase_r <= !phase_r;
        end
        else
        begin
            div_cnt_r <= div_cnt_r + DIV_W'(1);
        end
    end

    // two-flop synchronisers for both pins
    logic pd_meta_r;
    logic pd_sync_r;
    logic halt_meta_r;
    logic halt_sync_r;

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            pd_meta_r <= 1'b1;
            pd_sync_r <= 1'b1;
            halt_meta_r <= 1'b1;
            halt_sync_r <= 1'b1;
        end
        else
        begin
            pd_meta_r <= POWER_DOWN_N_I;
            pd_sync_r <= pd_meta_r;
            halt_meta_r <= CLOCK_HALT_N_I;
            halt_sync_r <= halt_meta_r;
        end
    end

    // samples taken on complement rising edges
    logic [1:0] pd_hist_r;
    logic [1:0] halt_hist_r;
    logic pd_low;
    logic pd_high;
    logic halt_low;
    logic halt_high;

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            pd_hist_r <= 2'h3;
            halt_hist_r <= 2'h3;
        end
        else if (comp_rise)
        begin
            pd_hist_r <= {pd_hist_r[0], pd_sync_r};
            halt_hist_r <= {halt_hist_r[0], halt_sync_r};
        end
    end

    assign pd_low = (pd_hist_r == 2'h0);
    assign pd_high = (pd_hist_r == 2'h3);
    assign halt_low = (halt_hist_r == 2'h0);
    assign halt_high = (halt_hist_r == 2'h3);

    // registers
    logic [1:0] mode_r;
    logic [NUM_PAIRS-1:0] stoppable_r;
    logic [NUM_PAIRS-1:0] out_enable_r;
    logic setup;
    logic access;
    logic addr_ok;

    assign setup = PSEL_I && !PENABLE_I;
    assign access = PSEL_I && PENABLE_I;
    assign addr_ok = (PADDR_I == clk_gate_pkg::OFS_MODE) || (PADDR_I == clk_gate_pkg::OFS_STOPPABLE) ||
        (PADDR_I == clk_gate_pkg::OFS_OUT_ENABLE) || (PADDR_I == clk_gate_pkg::OFS_STATUS);
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = access && !addr_ok;

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            mode_r <= clk_gate_pkg::MODE_RESET;
            stoppable_r <= NUM_PAIRS'(clk_gate_pkg::STOPPABLE_RESET);
            out_enable_r <= NUM_PAIRS'(clk_gate_pkg::OUT_ENABLE_RESET);
        end
        else if (access && PWRITE_I)
        begin
            if (PADDR_I == clk_gate_pkg::OFS_MODE)
            begin
                mode_r <= PWDATA_I[1:0];
            end
            if (PADDR_I == clk_gate_pkg::OFS_STOPPABLE)
            begin
                stoppable_r <= PWDATA_I[NUM_PAIRS-1:0];
            end
            if (PADDR_I == clk_gate_pkg::OFS_OUT_ENABLE)
            begin
                out_enable_r <= PWDATA_I[NUM_PAIRS-1:0];
            end
        end
    end

    logic sleep_tri;
    logic stop_tri;

    assign sleep_tri = mode_r[clk_gate_pkg::MODE_SLEEP_TRI_BIT];
    assign stop_tri = mode_r[clk_gate_pkg::MODE_STOP_TRI_BIT];

    // power-down sequencer
    clk_gate_pkg::pd_state_t pd_state_r;
    logic [LOCK_W-1:0] lock_cnt_r;
    logic lock_done;

    assign lock_done = (lock_cnt_r == LOCK_W'(RELOCK_CYCLES));

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            pd_state_r <= clk_gate_pkg::ST_RUN;
        end
        else
        begin
            unique case (pd_state_r)
                clk_gate_pkg::ST_RUN:
                    if (pd_low)
                    begin
                        pd_state_r <= clk_gate_pkg::ST_PARK_PEND;
                    end
                clk_gate_pkg::ST_PARK_PEND:
                    if (true_rise)
                    begin
                        pd_state_r <= clk_gate_pkg::ST_DOWN;
                    end
                clk_gate_pkg::ST_DOWN:
                    if (pd_high)
                    begin
                        pd_state_r <= clk_gate_pkg::ST_RELOCK;
                    end
                clk_gate_pkg::ST_RELOCK:
                    if (pd_low)
                    begin
                        pd_state_r <= clk_gate_pkg::ST_DOWN;
                    end
                    else if (lock_done && true_rise)
                    begin
                        pd_state_r <= clk_gate_pkg::ST_RUN;
                    end
            endcase
        end
    end

    // stand-in for PLL lock time after wake
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            lock_cnt_r <= '0;
        end
        else if (pd_state_r != clk_gate_pkg::ST_RELOCK)
        begin
            lock_cnt_r <= '0;
        end
        else if (!lock_done)
        begin
            lock_cnt_r <= lock_cnt_r + LOCK_W'(1);
        end
    end

    // PLL goes off on entry to ST_DOWN, one cycle before the registered outputs are parked
    assign PLL_EN_O = (pd_state_r != clk_gate_pkg::ST_DOWN);

    // clock halt: stop and restart on true rising edges so no runt pulse
    logic halted_r;
    logic halt_wake_r;
    logic resume_arm_r;
    logic [NUM_PAIRS-1:0] halt_mask_r;
    logic running;

    assign running = (pd_state_r == clk_gate_pkg::ST_RUN);

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            halted_r <= 1'b0;
            halt_wake_r <= 1'b0;
            resume_arm_r <= 1'b0;
            halt_mask_r <= '0;
        end
        else if (!halted_r)
        begin
            if (running && halt_low && true_rise)
            begin
                halted_r <= 1'b1;
                halt_mask_r <= stoppable_r;
            end
        end
        else if (!halt_wake_r)
        begin
            if (halt_high)
            begin
                halt_wake_r <= 1'b1;
            end
        end
        else if (true_rise)
        begin
            // one full period of drive-high before resuming keeps latency at least two periods
            if (resume_arm_r)
            begin
                halted_r <= 1'b0;
                halt_wake_r <= 1'b0;
                resume_arm_r <= 1'b0;
            end
            else
            begin
                resume_arm_r <= 1'b1;
            end
        end
    end

    // status read-back
    logic [31:0] status_w;
    logic [31:0] rd_nxt;

    always_comb
    begin
        status_w = 32'h0;
        status_w[clk_gate_pkg::STAT_PD_ACTIVE_BIT] = !running;
        status_w[clk_gate_pkg::STAT_HALTED_BIT] = halted_r;
        status_w[clk_gate_pkg::STAT_LOCKED_BIT] = running;
        status_w[clk_gate_pkg::STAT_PD_LEVEL_BIT] = pd_sync_r;
        status_w[clk_gate_pkg::STAT_HALT_LEVEL_BIT] = halt_sync_r;
    end

    always_comb
    begin
        rd_nxt = 32'h0;
        unique case (PADDR_I)
            clk_gate_pkg::OFS_MODE: rd_nxt[1:0] = mode_r;
            clk_gate_pkg::OFS_STOPPABLE: rd_nxt[NUM_PAIRS-1:0] = stoppable_r;
            clk_gate_pkg::OFS_OUT_ENABLE: rd_nxt[NUM_PAIRS-1:0] = out_enable_r;
            clk_gate_pkg::OFS_STATUS: rd_nxt = status_w;
            default: rd_nxt = 32'h0;
        endcase
    end

    // read data captured in the setup cycle so it comes from a flop in access
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            PRDATA_O <= 32'h0;
        end
        else if (setup && !PWRITE_I)
        begin
            PRDATA_O <= rd_nxt;
        end
    end

    // output pairs
    logic pd_park;
    logic pd_wake;

    assign pd_park = (pd_state_r == clk_gate_pkg::ST_DOWN);
    assign pd_wake = (pd_state_r == clk_gate_pkg::ST_RELOCK);

    for (genvar i = 0; i < NUM_PAIRS; i++)
    begin : g_pair
        pair_gate u_pair (
            .clk_i(MCLK_I),
            .rst_i(RST_I),
            .phase_i(phase_r),
            .enable_i(out_enable_r[i]),
            .pd_park_i(pd_park),
            .pd_wake_i(pd_wake),
            .sleep_tri_i(sleep_tri),
            .halted_i(halted_r && halt_mask_r[i]),
            .halt_wake_i(halt_wake_r),
            .stop_tri_i(stop_tri),
            .true_o(CLK_OUT_TRUE_O[i]),
            .true_oe_o(CLK_OUT_TRUE_OE_O[i]),
            .comp_o(CLK_OUT_COMP_O[i]),
            .comp_oe_o(CLK_OUT_COMP_OE_O[i])
        );
    end

endmodule

// >>> verification/power_ctl_model.sv
/*
  Power-management controller model driving the power-down and halt inputs.
  Assumes requests come from the bench on rising clock edges.
*/
module power_ctl_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pd_req_i,
    input wire logic halt_req_i,
    input wire logic glitch_i,
    output logic pd_n_o,
    output logic halt_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hold_r;
    logic pd_r;
    // a level moves only after standing two output periods
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pd_r <= 1'b1;
            halt_n_o <= 1'b1;
            hold_r <= 4'h0;
        end
        else if (hold_r < 4'h8)
            hold_r <= hold_r + 4'h1;
        else if (pd_r == pd_req_i || halt_n_o == halt_req_i)
        begin
            pd_r <= !pd_req_i;
            halt_n_o <= !halt_req_i;
            hold_r <= 4'h0;
        end
    end
    // glitch is raised only by the filter scenario
    assign pd_n_o = pd_r & ~glitch_i;
endmodule

// >>> verification/clock_output_stop_powerdown_sva.sv
/*
  Port checker for the output gating block.
  Assumes bind to the top module; single clock domain.
*/
module clock_output_stop_powerdown_chk #(
    parameter int unsigned NUM_PAIRS = 8
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic POWER_DOWN_N_I,
    input wire logic [NUM_PAIRS-1:0] CLK_OUT_TRUE_O,
    input wire logic [NUM_PAIRS-1:0] CLK_OUT_TRUE_OE_O,
    input wire logic [NUM_PAIRS-1:0] CLK_OUT_COMP_O,
    input wire logic [NUM_PAIRS-1:0] CLK_OUT_COMP_OE_O,
    input wire logic PLL_EN_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    bus_ready_a: assert property (PREADY_O) else $error("pready low");
    bus_err_a: assert property (PSEL_I && PENABLE_I && PADDR_I[1:0] == 2'h0 |-> PSLVERR_O == (PADDR_I > 12'h00c))
        else $error("pslverr wrong");
    bad_read_a: assert property (PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I > 12'h00c |-> PRDATA_O == 32'h0)
        else $error("unmapped read data");
    rdata_upper_a: assert property (PRDATA_O[31:8] == 24'h0) else $error("read upper bits set");
    pd_park_a: assert property (!PLL_EN_O && $past(!PLL_EN_O) |->
        CLK_OUT_TRUE_O == '1 && CLK_OUT_COMP_OE_O == '0) else $error("not parked in power-down");
    pair_inverse_a: assert property
        (((CLK_OUT_TRUE_OE_O & CLK_OUT_COMP_OE_O) & ~(CLK_OUT_TRUE_O ^ CLK_OUT_COMP_O)) == '0)
        else $error("driven pair not complementary");
    pd_filter_a: assert property ((PLL_EN_O && POWER_DOWN_N_I) [*8] |=> PLL_EN_O)
        else $error("power-down without request");
    pd_enter_a: assert property (($fell(POWER_DOWN_N_I) && PLL_EN_O) ##1 (!POWER_DOWN_N_I) [*7]
        |-> ##[0:16] !PLL_EN_O) else $error("power-down not entered");
endmodule
bind clock_output_stop_powerdown clock_output_stop_powerdown_chk #(.NUM_PAIRS(NUM_PAIRS)) u_chk (.*);

// >>> verification/clock_output_stop_powerdown_bench.sv
/*
  Self-checking bench: registers, clock halt, power-down and input filter.
  Assumes 125 MHz clock and a shortened relock count.
*/
module clock_output_stop_powerdown_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned RELOCK = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, pd_n, halt_n, pll_en;
    logic pd_req = 1'b0;
    logic halt_req = 1'b0;
    logic glitch = 1'b0;
    logic [7:0] t_o, t_oe, c_o, c_oe;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    clock_output_stop_powerdown #(.RELOCK_CYCLES(RELOCK)) u_dut (
        .MCLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .POWER_DOWN_N_I(pd_n), .CLOCK_HALT_N_I(halt_n), .CLK_OUT_TRUE_O(t_o), .CLK_OUT_TRUE_OE_O(t_oe),
        .CLK_OUT_COMP_O(c_o), .CLK_OUT_COMP_OE_O(c_oe), .PLL_EN_O(pll_en));
    power_ctl_model u_ctl (.clk_i(clk), .rst_i(rst), .pd_req_i(pd_req), .halt_req_i(halt_req),
        .glitch_i(glitch), .pd_n_o(pd_n), .halt_n_o(halt_n));
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && cyc < 20000);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_pll(input logic v);
        int n;
        n = 0;
        while (pll_en !== v && n < 80)
        begin
            @(negedge clk);
            n++;
        end
        chk("pll_en", {31'h0, v}, {31'h0, pll_en});
    endtask
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        apb(1'b0, clk_gate_pkg::OFS_MODE, 32'h0, q, e);
        chk("mode_reset", 32'h0, q);
        apb(1'b0, clk_gate_pkg::OFS_STOPPABLE, 32'h0, q, e);
        chk("stoppable_reset", 32'h0, q);
        apb(1'b0, clk_gate_pkg::OFS_OUT_ENABLE, 32'h0, q, e);
        chk("enable_reset", 32'hff, q);
        apb(1'b1, 12'h010, 32'h5, q, e);
        apb(1'b0, 12'h010, 32'h0, q, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, q);
        apb(1'b1, clk_gate_pkg::OFS_STOPPABLE, 32'hf, q, e);
        apb(1'b0, clk_gate_pkg::OFS_STOPPABLE, 32'h0, q, e);
        chk("stoppable_rw", 32'hf, q);
        apb(1'b0, clk_gate_pkg::OFS_STATUS, 32'h0, q, e);
        chk("status_idle", 32'h1c, q);
        apb(1'b1, clk_gate_pkg::OFS_OUT_ENABLE, 32'hfe, q, e);
        repeat (2) @(negedge clk);
        chk("disabled_oe", 32'h0, {30'h0, t_oe[0], c_oe[0]});
        apb(1'b1, clk_gate_pkg::OFS_OUT_ENABLE, 32'hff, q, e);
    endtask
    task automatic t_halt(input logic m);
        logic [31:0] q;
        logic e;
        logic [7:0] hi, lo;
        int n;
        apb(1'b1, clk_gate_pkg::OFS_MODE, {30'h0, m, 1'b0}, q, e);
        halt_req <= 1'b1;
        repeat (30) @(negedge clk);
        hi = 8'h0;
        lo = 8'hff;
        repeat (4)
        begin
            @(negedge clk);
            hi |= t_o;
            lo &= t_o;
            chk("halt_true_oe", {28'h0, m ? 4'h0 : 4'hf}, {28'h0, t_oe[3:0]});
            chk("halt_comp_oe", 32'h0, {28'h0, c_oe[3:0]});
        end
        // stopped pins stand still: high when driven, low when left undriven
        chk("stopped_level", {24'h0, m ? 8'h00 : 8'hff}, {24'h0, hi[3:0], lo[3:0]});
        chk("free_toggle", 32'hf, {28'h0, hi[7:4] & ~lo[7:4]});
        @(posedge clk);
        halt_req <= 1'b0;
        n = 0;
        // tristate mode first drives the stopped pins high, then resumes
        while (t_o[3:0] !== 4'hf && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        chk("wake_drive", 32'hf, {28'h0, t_oe[3:0]});
        while (t_o[3:0] === 4'hf && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        chk("resume_together", 32'h0, {28'h0, t_o[3:0]});
        chk("resume_latency", 32'h1, {31'h0, n >= 8 && n <= 25});
    endtask
    task automatic t_pd(input logic m);
        logic [31:0] q;
        logic e;
        int n;
        apb(1'b1, clk_gate_pkg::OFS_MODE, {31'h0, m}, q, e);
        apb(1'b1, clk_gate_pkg::OFS_STOPPABLE, 32'h0, q, e);
        pd_req <= 1'b1;
        wait_pll(1'b0);
        repeat (2) @(negedge clk);
        chk("pd_true", 32'hff, {24'h0, t_o});
        chk("pd_true_oe", m ? 32'h0 : 32'hff, {24'h0, t_oe});
        chk("pd_comp_oe", 32'h0, {24'h0, c_oe});
        apb(1'b0, clk_gate_pkg::OFS_STATUS, 32'h0, q, e);
        chk("status_down", 32'h11, q);
        @(posedge clk);
        pd_req <= 1'b0;
        wait_pll(1'b1);
        @(negedge clk);
        chk("wake_true_oe", 32'hff, {24'h0, t_oe});
        n = 0;
        while (t_o[0] === 1'b1 && n < RELOCK + 40)
        begin
            @(negedge clk);
            n++;
        end
        chk("relock_done", 32'h1, {31'h0, n < RELOCK + 40});
    endtask
    task automatic t_glitch;
        logic ok;
        ok = 1'b1;
        @(posedge clk);
        glitch <= 1'b1;
        @(posedge clk);
        glitch <= 1'b0;
        repeat (30)
        begin
            @(negedge clk);
            ok &= pll_en;
        end
        chk("pd_filter", 32'h1, {31'h0, ok});
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_halt(1'b0);
        t_halt(1'b1);
        t_pd(1'b0);
        t_pd(1'b1);
        t_glitch();
        summarize();
    end
endmodule
